// file: common/pil_pkg.sv
/*
  pil_pkg: shared constants and types for the priority interrupt logic.
  assumes a core-side port bus with 8-bit addresses and 16-bit data.
*/
package pil_pkg;

  // level count and widths
  localparam int unsigned LEVELS       = 8;
  localparam int unsigned LEVEL_W      = 3;
  localparam int unsigned PORT_ADDR_W  = 8;
  localparam int unsigned PORT_DATA_W  = 16;
  localparam int unsigned DEPTH_W      = 4;
  localparam int unsigned PORT_F_W     = 8;

  // port addresses
  localparam logic [7:0] ADDR_GEN_CTRL = 8'h38;  // holds the level mask in its low byte
  localparam logic [7:0] ADDR_PENDING  = 8'h39;

  // field positions inside the general control word
  localparam int unsigned MASK_LSB     = 0;
  localparam int unsigned CTRL_HI_LSB  = 8;

  // status register position of the global enable
  localparam int unsigned STAT_GIE_BIT = 4;

  // pending flag bit positions
  localparam int unsigned BIT_DAC      = 0;
  localparam int unsigned BIT_TIMER1   = 1;
  localparam int unsigned BIT_TIMER2   = 2;
  localparam int unsigned BIT_D2_RISE  = 3;
  localparam int unsigned BIT_D3_FALL  = 4;
  localparam int unsigned BIT_PF_FALL  = 5;
  localparam int unsigned BIT_D4_RISE  = 6;
  localparam int unsigned BIT_D5_FALL  = 7;

  // reset values
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_HI_RESET = 8'h00;
  localparam logic        GIE_RESET     = 1'b0;
  localparam logic [3:0]  DEPTH_RESET   = 4'h0;
  localparam logic [15:0] RDATA_RESET   = 16'h0000;

  // one port access from the core sequencer
  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } pil_port_req_t;

  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic dac_timer_underflow_source;
    logic first_timer_underflow_source;
    logic second_timer_underflow_source;
    logic level_six_request;   // comparator event for level six
    logic level_seven_request; // comparator event for level seven
  } pil_events_t;

endpackage

// file: core/pil_edge_det.sv
/*
  pil_edge_det: per-bit edge detector producing one-cycle pulses.
  assumes inputs already synchronous to sys_clk_in.
*/
`timescale 1ns/100ps
module pil_edge_det #(
  parameter int unsigned WIDTH  = 1,
  parameter bit          RISING = 1'b1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] pulse_out
);

  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  // history resets to the no-edge value so reset release never fakes an edge
  always_comb begin
    next_prev = level_in;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev <= RISING ? '1 : '0;
    end else begin
      prev <= next_prev;
    end
  end

  // combinational pulse, one cycle per edge
  assign pulse_out = RISING ? (level_in & ~prev) : (~level_in & prev);

endmodule

// file: core/pil_prio_sel.sv
/*
  pil_prio_sel: fixed-priority selector, bit 0 highest.
  assumes the candidate vector is already masked and enabled.
*/
`timescale 1ns/100ps
module pil_prio_sel #(
  parameter int unsigned LEVELS  = 8,
  parameter int unsigned LEVEL_W = 3
) (
  input  wire logic [LEVELS-1:0]  cand_in,
  output logic                    any_out,
  output logic [LEVEL_W-1:0]      level_out,
  output logic [LEVELS-1:0]       onehot_out
);

  // scan from lowest priority up so the highest one wins last
  always_comb begin
    level_out  = '0;
    onehot_out = '0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (cand_in[i]) begin
        level_out  = LEVEL_W'(i);
        onehot_out = LEVELS'(1) << i;
      end
    end
    any_out = |cand_in;
  end

endmodule

// file: core/pil_intc.sv
/*
  pil_intc: eight-level prioritised interrupt logic of the processor core.
  assumes the core sequencer gives one-cycle instruction strobes, a port bus
  synchronous to sys_clk_in, and holds the vector table and return stack.
  the core must hold service_take_in for one cycle only and must reach the
  vector through vector_level_out, which stands until the next take.
  peripheral pins and events are expected synchronous to the same clock.
*/
`timescale 1ns/100ps
module pil_intc (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_in,
  // core sequencer
  input  wire logic                       global_irq_on_instr_in,
  input  wire logic                       global_irq_off_instr_in,
  input  wire logic                       return_from_service_instr_in,
  input  wire logic                       service_take_in,
  output logic                            service_req_out,
  output logic [pil_pkg::LEVEL_W-1:0]     service_level_out,
  output logic [pil_pkg::LEVEL_W-1:0]     vector_level_out,
  output logic                            stat_gie_out,
  output logic                            in_service_out,
  // port bus
  input  wire pil_pkg::pil_port_req_t     port_req_in,
  output logic [pil_pkg::PORT_DATA_W-1:0] port_rdata_out,
  // peripheral trigger sources
  input  wire logic                       port_d5_in,
  input  wire logic                       port_d4_in,
  input  wire logic                       port_d3_in,
  input  wire logic                       port_d2_in,
  input  wire logic [pil_pkg::PORT_F_W-1:0] port_f_in,
  input  wire pil_pkg::pil_events_t       events_in,
  input  wire logic                       comparator_enable_in,
  // upper control byte for timers and other peripherals
  output logic [7:0]                      gen_ctrl_hi_out
);
  import pil_pkg::*;

  // registered state and their next values
  logic [LEVELS-1:0]      pending_flag_register;
  logic [LEVELS-1:0]      next_pending_flag_register;
  logic [LEVELS-1:0]      level_mask_register;
  logic [LEVELS-1:0]      next_level_mask_register;
  logic [7:0]             ctrl_hi;
  logic [7:0]             next_ctrl_hi;
  logic                   gie;
  logic                   next_gie;
  logic [DEPTH_W-1:0]     depth;
  logic [DEPTH_W-1:0]     next_depth;
  logic [LEVEL_W-1:0]     vec_level;
  logic [LEVEL_W-1:0]     next_vec_level;
  logic [PORT_DATA_W-1:0] rdata;
  logic [PORT_DATA_W-1:0] next_rdata;

  // combinational helpers
  logic [LEVELS-1:0]      trig;
  logic [LEVELS-1:0]      cand;
  logic [LEVELS-1:0]      sel_onehot;
  logic [LEVEL_W-1:0]     sel_level;
  logic                   sel_any;
  logic                   take;
  logic                   wr_flags;
  logic                   wr_ctrl;
  logic                   port_d5_fall;
  logic                   port_d4_rise;
  logic                   port_d3_fall;
  logic                   port_d2_rise;
  logic [PORT_F_W-1:0]    port_f_fall;
  logic [15:0]            stat_word;

  // port edge detectors
  // pins arrive already synchronous, so one history flop per pin is enough;
  // an asynchronous pin would need a two-stage synchroniser in front
  // each detector gives a one-cycle pulse, which the flag logic latches
  // reset history is chosen so that no edge shows right after release
  pil_edge_det #(.WIDTH(1), .RISING(1'b0)) u_d5 (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   (port_d5_in),
    .pulse_out  (port_d5_fall)
  );

  pil_edge_det #(.WIDTH(1), .RISING(1'b1)) u_d4 (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   (port_d4_in),
    .pulse_out  (port_d4_rise)
  );

  pil_edge_det #(.WIDTH(1), .RISING(1'b0)) u_d3 (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   (port_d3_in),
    .pulse_out  (port_d3_fall)
  );

  pil_edge_det #(.WIDTH(1), .RISING(1'b1)) u_d2 (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   (port_d2_in),
    .pulse_out  (port_d2_rise)
  );

  pil_edge_det #(.WIDTH(PORT_F_W), .RISING(1'b0)) u_pf (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   (port_f_in),
    .pulse_out  (port_f_fall)
  );

  // map each source onto its flag bit
  // port F is eight pins folded into one level: any falling pin sets it
  // timer and comparator events come in as ready-made one-cycle pulses
  always_comb begin
    trig                = '0;
    trig[BIT_DAC]       = events_in.dac_timer_underflow_source;
    trig[BIT_TIMER1]    = events_in.first_timer_underflow_source;
    trig[BIT_TIMER2]    = events_in.second_timer_underflow_source;
    trig[BIT_D2_RISE]   = port_d2_rise;
    trig[BIT_D3_FALL]   = port_d3_fall;
    trig[BIT_PF_FALL]   = |port_f_fall;
    // comparator takes over the two lowest levels when enabled
    trig[BIT_D4_RISE]   = comparator_enable_in ? events_in.level_six_request
                                               : port_d4_rise;
    trig[BIT_D5_FALL]   = comparator_enable_in ? events_in.level_seven_request
                                               : port_d5_fall;
  end

  // candidates: pending and unmasked; mask never gates capture
  // the selector is pure logic, so all eight levels are judged in the
  // same cycle and a change of mask shows in the request at once
  assign cand = pending_flag_register & level_mask_register;

  pil_prio_sel #(.LEVELS(LEVELS), .LEVEL_W(LEVEL_W)) u_sel (
    .cand_in    (cand),
    .any_out    (sel_any),
    .level_out  (sel_level),
    .onehot_out (sel_onehot)
  );

  // request is a level, so a pending level left over after a return or
  // a re-enable is served next without waiting for a fresh edge
  assign service_req_out   = gie & sel_any;
  assign service_level_out = sel_level;
  // a take without a live request is ignored: nothing cleared, no vector
  // the core may raise its take late; the request must still stand then
  assign take              = service_take_in & service_req_out;

  // only writes have side effects; reads of either register are harmless
  // and the rd strobe is used solely for the read data register
  assign wr_flags = port_req_in.wr & (port_req_in.addr == ADDR_PENDING);
  assign wr_ctrl  = port_req_in.wr & (port_req_in.addr == ADDR_GEN_CTRL);

  // pending flags: port write, branch clear, then triggers win over both
  // a trigger landing on a write or a branch clear is never lost, at the
  // price that software cannot clear a flag whose event fires that cycle
  // a write replaces all eight bits, so software must read-modify-write
  // a write beats the branch clear, so software keeps the last word
  always_comb begin
    next_pending_flag_register = pending_flag_register;
    if (wr_flags) begin
      next_pending_flag_register = port_req_in.wdata[LEVELS-1:0];
    end else if (take) begin
      next_pending_flag_register = pending_flag_register & ~sel_onehot;
    end
    next_pending_flag_register = next_pending_flag_register | trig;
  end

  // no reset on purpose: the flags survive a reset while powered
  // in simulation they start unknown; boot code should write them first
  // keeping them lets an event that came with the reset be served after it
  always_ff @(posedge sys_clk_in) begin
    pending_flag_register <= next_pending_flag_register;
  end

  // control word: mask in the low byte, general control above it
  // the upper byte is stored and exported untouched for the timer and
  // clock-source selects; this block only returns it on a port read
  // mask bits and upper byte are written together by one port write
  always_comb begin
    next_level_mask_register = level_mask_register;
    next_ctrl_hi             = ctrl_hi;
    if (wr_ctrl) begin
      next_level_mask_register = port_req_in.wdata[MASK_LSB +: LEVELS];
      next_ctrl_hi             = port_req_in.wdata[CTRL_HI_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_mask_register <= MASK_RESET;
      ctrl_hi             <= CTRL_HI_RESET;
    end else begin
      level_mask_register <= next_level_mask_register;
      ctrl_hi             <= next_ctrl_hi;
    end
  end

  // global enable; a branch clears it even against a same-cycle enable
  // an off instruction beats an on instruction in the same cycle
  // the branch clear is what keeps a second request from being taken
  // before the routine has had a chance to save its context
  always_comb begin
    next_gie = gie;
    if (global_irq_on_instr_in) begin
      next_gie = 1'b1;
    end
    if (global_irq_off_instr_in) begin
      next_gie = 1'b0;
    end
    if (take) begin
      next_gie = 1'b0;
    end
  end

  // service nesting depth and captured vector level
  // depth saturates at fifteen; deeper nesting is not tracked, so
  // in_service_out can drop early if software nests beyond that
  // a take and a return in one cycle cancel and leave the depth alone
  always_comb begin
    next_depth     = depth;
    next_vec_level = vec_level;
    if (take) begin
      next_vec_level = sel_level;
    end
    // the core stack restores the program; depth only tracks it
    if (take && !return_from_service_instr_in) begin
      if (depth != '1) begin
        next_depth = depth + DEPTH_W'(1);
      end
    end else if (!take && return_from_service_instr_in) begin
      if (depth != '0) begin
        next_depth = depth - DEPTH_W'(1);
      end
    end
  end

  // read data registered one cycle after the read strobe
  // read data holds between reads so the core may sample it late
  // unmapped addresses read as zero rather than keeping stale data
  always_comb begin
    next_rdata = rdata;
    if (port_req_in.rd) begin
      unique case (port_req_in.addr)
        ADDR_GEN_CTRL: next_rdata = {ctrl_hi, level_mask_register};
        ADDR_PENDING:  next_rdata = {8'h00, pending_flag_register};
        default:       next_rdata = RDATA_RESET;
      endcase
    end
  end

  // one register bank for enable, depth, vector and read data
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gie       <= GIE_RESET;
      depth     <= DEPTH_RESET;
      vec_level <= '0;
      rdata     <= RDATA_RESET;
    end else begin
      gie       <= next_gie;
      depth     <= next_depth;
      vec_level <= next_vec_level;
      rdata     <= next_rdata;
    end
  end

  // status word view: only the enable bit belongs to this block, the
  // arithmetic flags around it live in the core and read as zero here
  // keeping the bit position in one constant avoids a second copy of it
  always_comb begin
    stat_word               = '0;
    stat_word[STAT_GIE_BIT] = gie;
  end

  // outputs
  // the core muxes its own flags around bit four when it reads status
  assign stat_gie_out     = stat_word[STAT_GIE_BIT];
  assign in_service_out   = (depth != '0);
  assign vector_level_out = vec_level;
  assign port_rdata_out   = rdata;
  assign gen_ctrl_hi_out  = ctrl_hi;

endmodule

// file: verification/pil_asserts.sv
/*
  pil_asserts: port timing checks for the interrupt logic.
  assumes binding onto pil_intc; one clock domain.
*/
`timescale 1ns/100ps
module pil_asserts (
  input wire logic                   sys_clk_in,
  input wire logic                   rst_in,
  input wire logic                   global_irq_on_instr_in,
  input wire logic                   global_irq_off_instr_in,
  input wire logic                   service_take_in,
  input wire logic                   service_req_out,
  input wire logic [2:0]             service_level_out,
  input wire logic [2:0]             vector_level_out,
  input wire logic                   stat_gie_out,
  input wire logic                   in_service_out,
  input wire pil_pkg::pil_port_req_t port_req_in,
  input wire logic [15:0]            port_rdata_out
);
  import pil_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic took;
  logic on;
  logic off;
  // a take only counts while the request stands
  assign took = service_take_in && service_req_out;
  assign on = global_irq_on_instr_in;
  assign off = global_irq_off_instr_in;
  a_take_gie: assert property (took |=> !stat_gie_out)
    else $error("enable kept after take");
  a_take_vec: assert property (took |=> vector_level_out == $past(service_level_out))
    else $error("wrong vector level");
  a_take_depth: assert property (took |=> in_service_out)
    else $error("not in service");
  a_req_gie: assert property (!stat_gie_out && !on |=> !service_req_out)
    else $error("request while disabled");
  a_on_sets: assert property (on && !off && !took |=> stat_gie_out)
    else $error("enable not set");
  a_off_clears: assert property (off |=> !stat_gie_out)
    else $error("enable not cleared");
  a_gie_hold: assert property (!on && !off && !took |=> $stable(stat_gie_out))
    else $error("enable moved");
  a_vec_hold: assert property (!took |=> $stable(vector_level_out))
    else $error("vector moved");
  a_rdata_hold: assert property (!port_req_in.rd |=> $stable(port_rdata_out))
    else $error("read data moved");
  c_take: cover property (took);
  c_off: cover property (off ##[1:40] on);
  c_read: cover property (port_req_in.rd && port_req_in.addr == ADDR_PENDING);
endmodule
bind pil_intc pil_asserts u_chk (.*);

// file: verification/pil_core_model.sv
/*
  pil_core_model: core sequencer stand-in taking service branches.
  assumes a level request; answers at once or some cycles late.
*/
`timescale 1ns/100ps
module pil_core_model (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic req_in,
  input  wire logic slow_in,
  output logic      take_out = 1'b0
);
  logic [1:0] wait_cnt;
  // one-cycle take, moved at falling edges like the bench
  always @(negedge sys_clk_in or posedge rst_in) begin
    if (rst_in || take_out || !req_in) begin
      take_out <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (!slow_in || wait_cnt == 2'h3) begin
      take_out <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1; // slow core lets the request wait
    end
  end
endmodule

// file: verification/tb_top.sv
/*
  tb_top: directed bench for pil_intc over its port bus and strobes.
  assumes pil_core_model takes branches; inputs move at falling edges.
*/
`timescale 1ns/100ps
module tb_top;
  import pil_pkg::*;
  localparam logic [7:0] PA = ADDR_PENDING;
  localparam logic [7:0] MA = ADDR_GEN_CTRL;
  logic          sys_clk_in = 1'b0, rst_in = 1'b1, comparator_enable_in = 1'b0, slow = 1'b0;
  logic          port_d5_in = 1'b1, port_d4_in = 1'b0, port_d3_in = 1'b1, port_d2_in = 1'b0;
  logic [7:0]    port_f_in = 8'hff;
  logic [2:0]    ins_v = 3'h0;
  pil_port_req_t port_req_in = '0;
  pil_events_t   events_in = '0;
  logic          global_irq_on_instr_in, global_irq_off_instr_in, return_from_service_instr_in;
  logic          service_take_in, service_req_out, stat_gie_out, in_service_out;
  logic [2:0]    service_level_out, vector_level_out;
  logic [7:0]    gen_ctrl_hi_out;
  logic [15:0]   port_rdata_out;
  int            errors = 0;
  int            total_checks = 0;
  int            take_cnt = 0;
  int            seen_cnt = 0;

  // instruction strobes: on, off, return
  assign {global_irq_on_instr_in, global_irq_off_instr_in, return_from_service_instr_in} = ins_v;
  always #25 sys_clk_in = ~sys_clk_in;
  pil_intc u_dut (.*);
  pil_core_model u_core (.sys_clk_in, .rst_in, .req_in(service_req_out), .slow_in(slow),
                         .take_out(service_take_in));
  // count branches taken so serve cannot miss a short take pulse
  always @(posedge sys_clk_in) begin
    if (service_take_in === 1'b1) begin
      take_cnt <= take_cnt + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one port access; a read compares d with the answer
  task automatic io(input logic w, input logic [7:0] a, input logic [15:0] d);
    port_req_in = '{a, w, !w, w ? d : 16'h0};
    @(negedge sys_clk_in) port_req_in = '0;
    @(negedge sys_clk_in);
    if (!w) chk(port_rdata_out, d);
  endtask
  task automatic ins(input logic [2:0] v);
    ins_v = v;
    @(negedge sys_clk_in) ins_v = 3'h0;
    @(negedge sys_clk_in);
  endtask
  // fire one source; nine means comparator seven
  task automatic trig(input int i);
    case (i)
      0: events_in.dac_timer_underflow_source = 1'b1;
      1: events_in.first_timer_underflow_source = 1'b1;
      2: events_in.second_timer_underflow_source = 1'b1;
      3: port_d2_in = 1'b1;
      4: port_d3_in = 1'b0;
      5: port_f_in[3] = 1'b0;
      6: port_d4_in = 1'b1;
      7: port_d5_in = 1'b0;
      8: events_in.level_six_request = 1'b1;
      default: events_in.level_seven_request = 1'b1;
    endcase
    @(negedge sys_clk_in) events_in = '0;
    {port_d5_in, port_d4_in, port_d3_in, port_d2_in, port_f_in} = 12'ha_ff;
    repeat (3) @(negedge sys_clk_in);
  endtask
  // wait for one new take, then check the branch; no take is a mismatch
  task automatic serve(input logic [2:0] exp);
    int n;
    n = 0;
    while (take_cnt == seen_cnt && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk(16'(take_cnt - seen_cnt), 16'h1);
    seen_cnt = take_cnt;
    @(negedge sys_clk_in) chk(16'(vector_level_out), 16'(exp));
    chk(16'(stat_gie_out), 16'h0);
    chk(16'(in_service_out), 16'h1);
  endtask
  task automatic test_done;
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog: the run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    errors++;
    test_done();
  end

  initial begin
    repeat (6) @(negedge sys_clk_in);
    rst_in = 1'b0;
    io(1, PA, 16'h0);
    io(0, MA, 16'h0);
    chk(16'(stat_gie_out), 16'h0);
    io(1, MA, 16'h5a00);
    io(0, MA, 16'h5a00);
    chk(16'(gen_ctrl_hi_out), 16'h5a);
    // each source alone, all levels masked
    for (int i = 0; i < 8; i++) begin
      io(1, PA, 16'h0);
      trig(i);
      io(0, PA, 16'(1 << i));
    end
    comparator_enable_in = 1'b1;
    io(1, PA, 16'h0);
    trig(6);
    trig(7);
    io(0, PA, 16'h0);
    trig(8);
    trig(9);
    io(0, PA, 16'h00c0);
    comparator_enable_in = 1'b0;
    // level zero pending but masked: nothing may move
    io(1, MA, 16'h00fe);
    io(1, PA, 16'h1);
    ins(3'h4);
    repeat (4) @(negedge sys_clk_in);
    chk(16'(stat_gie_out), 16'h1);
    chk(16'(service_req_out), 16'h0);
    io(0, PA, 16'h1);
    ins(3'h2);
    io(1, MA, 16'h00ff);
    trig(1);
    io(0, PA, 16'h3);
    ins(3'h4);
    serve(3'h0);
    io(0, PA, 16'h2);
    ins(3'h4);
    ins(3'h1);
    serve(3'h1);
    // all eight pending, slow core, served in order
    slow = 1'b1;
    io(1, PA, 16'h00ff);
    ins(3'h4);
    for (int i = 0; i < 8; i++) begin
      chk(16'(service_req_out), 16'h1);
      chk(16'(service_level_out), 16'(i));
      serve(3'(i));
      ins(3'h4);
      ins(3'h1);
    end
    io(0, PA, 16'h0);
    trig(2);
    serve(3'h2);
    io(1, PA, 16'h005a);
    rst_in = 1'b1;
    @(negedge sys_clk_in) rst_in = 1'b0;
    io(0, PA, 16'h005a);
    io(0, MA, 16'h0);
    test_done();
  end
endmodule
